/* File: rpm_pkg.sv */
// Package for the redriver power and mode controller.
// Assumes a single 20 MHz clock domain.
package rpm_pkg;
  localparam int          CLK_MHZ          = 20;
  // Register offsets
  localparam logic [7:0]  OFS_MISC         = 8'h09;
  localparam logic [7:0]  OFS_DRV          = 8'h0c;
  localparam logic [7:0]  OFS_LANE         = 8'h30;
  localparam logic [7:0]  OFS_STAT         = 8'h0a;
  // Field positions
  localparam int          MISC_PDN_BIT     = 3;
  localparam int          MISC_SPEC_BIT    = 5;
  localparam int          MISC_RATIO_BIT   = 1;
  // Reset values
  localparam logic [7:0]  MISC_RST         = 8'h00;
  localparam logic [7:0]  DRV_RST          = 8'h00;
  localparam logic [7:0]  LANE_RST         = 8'h00;
  // Special-mode defaults: all lanes on, top rate code, nominal swing
  localparam logic [5:0]  SPEC_LANE_DEF    = 6'h3f;
  localparam logic [2:0]  SPEC_SWING_DEF   = 3'h0;
  // Times
  localparam int          HPD_LOW_US       = 2000;
  localparam int          HPD_LOW_CYC      = HPD_LOW_US * CLK_MHZ;
  localparam int          EXAM_MIN_US      = 3;
  localparam int          EXAM_MAX_US      = 5;
  localparam int          EXAM_CYC         = EXAM_MIN_US * CLK_MHZ;
  localparam int          CLK_EDGES_MIN    = 4;
  typedef enum logic [1:0]
  {
    ST_PDN   = 2'b00,
    ST_STBY1 = 2'b01,
    ST_STBY2 = 2'b11,
    ST_NORM  = 2'b10
  } rpm_state_t;
endpackage

/* File: rpm_sync_if.sv */
// Interface carrying synchronised pin levels to the main module.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
interface rpm_sync_if;
  logic oe;
  logic hpd;
  logic lclk;
  modport src (output oe, output hpd, output lclk);
  modport dst (input oe, input hpd, input lclk);
endinterface

/* File: rpm_sync.sv */
// Two-flop synchronisers for the asynchronous pins.
// Assumes pins are fully asynchronous to clk.
`timescale 1ns/10ps
module rpm_sync
(
  // Clock and reset
  input  wire logic   clk,
  input  wire logic   reset_n,
  // Raw pins
  input  wire logic   oe_pin,
  input  wire logic   hpd_pin,
  input  wire logic   lclk_pin,
  // Synchronised levels
  rpm_sync_if.src     so
);
  logic [2:0] s1_reg;
  logic [2:0] s2_reg;
  // ==========================================
  // Double flop; first stage read only by second
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      s1_reg <= 3'h0;
      s2_reg <= 3'h0;
    end
    else
    begin
      s1_reg <= {oe_pin, hpd_pin, lclk_pin};
      s2_reg <= s1_reg;
    end
  end
  assign so.oe   = s2_reg[2];
  assign so.hpd  = s2_reg[1];
  assign so.lclk = s2_reg[0];
endmodule // rpm_sync

/* File: rpm_ctrl.sv */
// Power-state and mode controller of a level-shifting redriver.
// Assumes a 20 MHz clk, byte-wide register port from the config slave.
// How it works
// - Misc register bit 5 set enters special mode, I2C-only config.
// - Special mode self-configures; no link training, aux not passed.
// - Special mode turns on all four lanes at top rate, nominal swing.
// - Special mode swing for all lanes from driver register bits 7:5.
// - Special mode pre-emphasis for all lanes from driver bits 1:0.
// - Special mode lane on/off and rate from lane register bits 7:2.
// - Output enable low shuts all blocks but hot-plug; lanes, config, DDC off.
// - Output enable rising edge resets device; host must reconfigure.
// - Misc register bit 3 set enters power-down.
// - Enable high and hot-plug low over 2 ms enters power-down.
// - Hot-plug high without valid clock stays in standby.
// - After hot-plug, outputs enable only from signal detector result.
// - Source hot-plug output copies sink hot-plug input always.
// - All registers, clock ratio flag included, clear on power-down.
// - Standby examines clock-lane activity 3 to 5 us before deciding.
// - Clock found goes normal; none found returns to standby stage 1.
// - Standby: data receivers off, clock receiver on, outputs high-Z.
`timescale 1ns/10ps
module rpm_ctrl
  import rpm_pkg::*;
#(
  parameter int HPD_LOW_CYCLES = HPD_LOW_CYC,
  parameter int NUM_LANES      = 4
)
(
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 reset_n,
  // Pins from outside the domain
  input  wire logic                 oe_pin,
  input  wire logic                 sink_hotplug_in,
  input  wire logic                 clock_lane_in,
  // Register port from the local config slave
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  input  wire logic [7:0]           reg_addr,
  input  wire logic [7:0]           reg_wdata,
  output logic      [7:0]           reg_rdata,
  // Hot-plug out
  output logic                      source_hotplug_out,
  // Lane and bus controls
  output logic [NUM_LANES-1:0]      lane_tx_en,
  output logic [2:0]                data_rx_en,
  output logic                      clk_rx_en,
  output logic                      cfg_bus_en,
  output logic                      ddc_en,
  output logic [2:0]                swing_sel,
  output logic [1:0]                preemph_sel,
  output logic [5:0]                rate_sel,
  output logic                      special_mode,
  output logic [1:0]                power_state
);
  rpm_sync_if si ();
  logic [7:0]   misc_mode_control_reg;
  logic [7:0]   global_driver_control_reg;
  logic [7:0]   lane_enable_rate_reg;
  logic         oe_d_reg;
  logic [31:0]  hpd_cnt_reg;
  logic [7:0]   exam_cnt_reg;
  logic [3:0]   edge_cnt_reg;
  logic         lclk_d_reg;
  rpm_state_t   state_reg;
  rpm_state_t   state_next;
  logic         oe_rise;
  logic         hpd_timeout;
  logic         pdn;
  logic         lclk_edge;

  // ==========================================
  // Pin synchronisers
  rpm_sync u_sync
  (
    .clk      (clk),
    .reset_n  (reset_n),
    .oe_pin   (oe_pin),
    .hpd_pin  (sink_hotplug_in),
    .lclk_pin (clock_lane_in),
    .so       (si.src)
  );

  // Edge helpers on synchronised levels
  assign oe_rise   = si.oe && !oe_d_reg;
  assign lclk_edge = si.lclk != lclk_d_reg;
  assign hpd_timeout = hpd_cnt_reg >= 32'(HPD_LOW_CYCLES);
  // Any power-down cause
  assign pdn = !si.oe || misc_mode_control_reg[MISC_PDN_BIT]
               || hpd_timeout;

  // ==========================================
  // Delayed copies for edge detection
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      oe_d_reg   <= 1'b0;
      lclk_d_reg <= 1'b0;
    end
    else
    begin
      oe_d_reg   <= si.oe;
      lclk_d_reg <= si.lclk;
    end
  end

  // ==========================================
  // Hot-plug low timer; saturates so timeout holds
  always_ff @(posedge clk)
  begin
    if (!reset_n || !si.oe || si.hpd)
      hpd_cnt_reg <= 32'h0000_0000;
    else if (!hpd_timeout)
      hpd_cnt_reg <= hpd_cnt_reg + 32'h0000_0001;
  end

  // ==========================================
  // Registers; cleared in power-down and on enable rise
  always_ff @(posedge clk)
  begin
    if (!reset_n || oe_rise || state_reg == ST_PDN && pdn)
    begin
      misc_mode_control_reg     <= MISC_RST;
      global_driver_control_reg <= DRV_RST;
      lane_enable_rate_reg      <= LANE_RST;
    end
    else if (reg_wr && state_reg != ST_PDN || reg_wr && !pdn)
    begin
      case (reg_addr)
        OFS_MISC:
        begin
          misc_mode_control_reg <= reg_wdata;
          // Entering special mode loads its defaults
          if (reg_wdata[MISC_SPEC_BIT] &&
              !misc_mode_control_reg[MISC_SPEC_BIT])
          begin
            lane_enable_rate_reg      <= {SPEC_LANE_DEF, 2'b00};
            global_driver_control_reg <= {SPEC_SWING_DEF, 5'h00};
          end
        end
        OFS_DRV:  global_driver_control_reg <= reg_wdata;
        OFS_LANE: lane_enable_rate_reg      <= reg_wdata;
        default:  misc_mode_control_reg     <= misc_mode_control_reg;
      endcase
    end
  end

  // ==========================================
  // Clock-lane examination window and edge counter
  always_ff @(posedge clk)
  begin
    if (!reset_n || state_reg != ST_STBY2)
    begin
      exam_cnt_reg <= 8'h00;
      edge_cnt_reg <= 4'h0;
    end
    else
    begin
      exam_cnt_reg <= exam_cnt_reg + 8'h01;
      if (lclk_edge && edge_cnt_reg != 4'hf)
        edge_cnt_reg <= edge_cnt_reg + 4'h1;
    end
  end

  // ==========================================
  // Power state machine
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ST_PDN:
        if (!pdn && si.hpd)
          state_next = ST_STBY1;
      ST_STBY1:
        if (pdn)
          state_next = ST_PDN;
        else if (lclk_edge)
          state_next = ST_STBY2;
      ST_STBY2:
        if (pdn)
          state_next = ST_PDN;
        else if (exam_cnt_reg >= 8'(EXAM_CYC - 1))
          state_next = (edge_cnt_reg >= 4'(CLK_EDGES_MIN))
                       ? ST_NORM : ST_STBY1;
      ST_NORM:
        if (pdn)
          state_next = ST_PDN;
        else if (!si.hpd)
          state_next = ST_STBY1;
      default:
        state_next = ST_PDN;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n || oe_rise)
      state_reg <= ST_PDN;
    else
      state_reg <= state_next;
  end

  // ==========================================
  // Registered outputs
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      source_hotplug_out <= 1'b0;
      lane_tx_en         <= '0;
      data_rx_en         <= 3'h0;
      clk_rx_en          <= 1'b0;
      cfg_bus_en         <= 1'b0;
      ddc_en             <= 1'b0;
      swing_sel          <= 3'h0;
      preemph_sel        <= 2'h0;
      rate_sel           <= 6'h00;
      special_mode       <= 1'b0;
      power_state        <= 2'h0;
    end
    else
    begin
      source_hotplug_out <= si.hpd;
      special_mode <= misc_mode_control_reg[MISC_SPEC_BIT];
      swing_sel    <= global_driver_control_reg[7:5];
      preemph_sel  <= global_driver_control_reg[1:0];
      rate_sel     <= lane_enable_rate_reg[7:2];
      power_state  <= state_reg;
      // Enable decode from state, enable level and special-mode bit
      cfg_bus_en   <= state_reg != ST_PDN || si.oe;
      ddc_en       <= si.oe && !misc_mode_control_reg[MISC_SPEC_BIT];
      clk_rx_en    <= state_reg != ST_PDN;
      data_rx_en   <= state_reg == ST_NORM ? 3'h7 : 3'h0;
      // Outputs driven only after detector says clock
      if (state_reg != ST_NORM)
        lane_tx_en <= '0;
      else if (misc_mode_control_reg[MISC_SPEC_BIT])
        lane_tx_en <= lane_enable_rate_reg[NUM_LANES+1:2];
      else
        lane_tx_en <= '1;
    end
  end

  // Read-back; status shows state and hot-plug
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      case (reg_addr)
        OFS_MISC: reg_rdata <= misc_mode_control_reg;
        OFS_DRV:  reg_rdata <= global_driver_control_reg;
        OFS_LANE: reg_rdata <= lane_enable_rate_reg;
        OFS_STAT: reg_rdata <= {5'h00, si.hpd, state_reg};
        default:  reg_rdata <= 8'h00;
      endcase
  end

  // ==========================================
  // Assertions
  AST_HPD_COPY: assert property (@(posedge clk) disable iff (!reset_n)
    source_hotplug_out == $past(si.hpd))
    else $error("hotplug out not a copy");
  AST_OE_LOW_PDN: assert property (@(posedge clk) disable iff (!reset_n)
    !si.oe |=> state_reg == ST_PDN)
    else $error("enable low not in power down");
  AST_PDN_BIT: assert property (@(posedge clk) disable iff (!reset_n)
    misc_mode_control_reg[MISC_PDN_BIT] |=> state_reg == ST_PDN)
    else $error("pdn bit ignored");
  AST_OE_RISE_CLR: assert property (@(posedge clk) disable iff (!reset_n)
    oe_rise |=> misc_mode_control_reg == MISC_RST)
    else $error("enable rise did not reset");
  AST_PDN_CLEARS: assert property (@(posedge clk) disable iff (!reset_n)
    state_reg == ST_PDN && pdn |=> lane_enable_rate_reg == LANE_RST)
    else $error("registers not cleared");
  AST_HPD_TIMER: assert property (@(posedge clk) disable iff (!reset_n)
    si.hpd |=> hpd_cnt_reg == 32'h0000_0000)
    else $error("hpd timer not restarted");
  AST_STBY_OFF: assert property (@(posedge clk) disable iff (!reset_n)
    state_reg == ST_STBY1 |=> lane_tx_en == '0 && data_rx_en == 3'h0)
    else $error("standby outputs active");
  AST_EXAM_LEN: assert property (@(posedge clk) disable iff (!reset_n)
    state_reg == ST_STBY1 ##1 state_reg == ST_STBY2 && !pdn
    |-> (state_reg == ST_STBY2 || pdn) [*8])
    else $error("examination too short");
  AST_NORM_DET: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(state_reg == ST_NORM) |-> $past(state_reg) == ST_STBY2)
    else $error("normal without detector");
  AST_SPEC_SWING: assert property (@(posedge clk) disable iff (!reset_n)
    special_mode |-> swing_sel == $past(global_driver_control_reg[7:5]))
    else $error("swing not from register");
  COV_NORMAL: cover property (@(posedge clk) state_reg == ST_NORM);
  COV_RETURN: cover property (@(posedge clk)
    state_reg == ST_STBY2 ##1 state_reg == ST_STBY1);
  COV_SPECIAL: cover property (@(posedge clk) special_mode && |lane_tx_en);
  COV_TIMEOUT: cover property (@(posedge clk) hpd_timeout);
endmodule // rpm_ctrl

/* File: rpm_src_model.sv */
// Source-side partner: drives clock-lane activity and the hot-plug level.
// Assumes the block samples both pins asynchronously with its own clock.
`timescale 1ns/10ps
module rpm_src_model
(
  // Pins toward the block
  output logic clock_lane_in,
  output logic sink_hotplug_in
);
  // ==========================================================
  // Idle levels
  // Lane stands still at zero between bursts; hot-plug starts high
  initial
  begin
    clock_lane_in = 1'b0;
    sink_hotplug_in = 1'b1;
  end

  // ==========================================================
  // Bursts of a 400 ns lane clock, odd offset keeps phase unrelated
  task automatic burst(input int n);
    #7;
    repeat (n)
    begin
      clock_lane_in = 1'b1;
      #200;
      clock_lane_in = 1'b0;
      #200;
    end
  endtask

  // Hot-plug level change
  task automatic set_hpd(input logic v);
    sink_hotplug_in = v;
  endtask
endmodule // rpm_src_model

/* File: redriver_power_mode_control_bench.sv */
// Self-checking bench for the redriver power and mode controller.
// Assumes rpm_pkg, rpm_ctrl and the partner model are compiled first.
`timescale 1ns/10ps
module redriver_power_mode_control_bench;
  import rpm_pkg::*;
  // ==========================================================
  // Signals
  logic        clk, reset_n, oe_pin, reg_wr, reg_rd;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, d, a;
  logic        lane_in, hpd_in, hpd_out, clk_rx_en, cfg_bus_en, ddc_en;
  logic [3:0]  lane_tx_en;
  logic [2:0]  data_rx_en, swing_sel;
  logic [1:0]  preemph_sel, power_state;
  logic [5:0]  rate_sel;
  logic        special_mode;
  logic [31:0] seed = 32'd48383;
  int          err_total = 0, n_checks = 0, cycles = 0;

  // Short hot-plug timeout keeps the run brief
  rpm_ctrl #(.HPD_LOW_CYCLES(50), .NUM_LANES(4)) u_rpm_ctrl (
    .clk(clk), .reset_n(reset_n), .oe_pin(oe_pin),
    .sink_hotplug_in(hpd_in), .clock_lane_in(lane_in),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .source_hotplug_out(hpd_out), .lane_tx_en(lane_tx_en),
    .data_rx_en(data_rx_en), .clk_rx_en(clk_rx_en),
    .cfg_bus_en(cfg_bus_en), .ddc_en(ddc_en), .swing_sel(swing_sel),
    .preemph_sel(preemph_sel), .rate_sel(rate_sel),
    .special_mode(special_mode), .power_state(power_state));
  rpm_src_model u_rpm_src_model (.clock_lane_in(lane_in),
    .sink_hotplug_in(hpd_in));

  // ==========================================================
  // Helpers
  function automatic logic [7:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  // Rate code sits in the upper six bits of the lane register
  function automatic logic [7:0] exp_rate(input logic [7:0] v);
    return {2'h0, v[7:2]};
  endfunction
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cs(input logic [1:0] s);
    chk({6'h0, power_state}, {6'h0, s});
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = v;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask
  // Read data is registered, so it is settled one cycle after the strobe
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk);
    reg_rd = 1'b0;
    chk(reg_rdata, exp);
  endtask
  task automatic summarize();
    $display("checks=%0d mismatches=%0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ==========================================================
  // Clock and hang guard
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_total++;
      summarize();
    end
  end

  // ==========================================================
  // Main sequence
  initial
  begin
    {reset_n, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    oe_pin = 1'b1;
    repeat (20) @(negedge clk);
    reset_n = 1'b1;
    cyc(10);
    cs(ST_STBY1);
    chk({clk_rx_en, data_rx_en, lane_tx_en}, 8'h80);
    chk({cfg_bus_en, ddc_en, hpd_out}, 8'h07);
    rdc(OFS_DRV, DRV_RST);
    rdc(8'h55, 8'h00);
    rdc(OFS_STAT, {5'h0, 1'b1, ST_STBY1});
    $display("test reset done");
    // Two edges of noise: examined, then back to stage one
    u_rpm_src_model.burst(1);
    cyc(30);
    cs(ST_STBY2);
    cyc(60);
    cs(ST_STBY1);
    u_rpm_src_model.burst(12);
    cyc(2);
    cs(ST_NORM);
    chk({1'b0, data_rx_en, lane_tx_en}, 8'h7f);
    $display("test clock detect done");
    // Random writes and read-backs of the driver and lane registers
    repeat (4)
    begin
      d = xs();
      wr(OFS_DRV, d);
      rdc(OFS_DRV, d);
      wr(OFS_LANE, ~d);
      rdc(OFS_LANE, ~d);
    end
    // Random unmapped offsets; mapped ones are moved off the map
    repeat (3)
    begin
      a = xs();
      if (a == OFS_MISC || a == OFS_DRV || a == OFS_LANE || a == OFS_STAT)
        a = a ^ 8'h40;
      wr(a, xs());
      rdc(a, 8'h00);
    end
    rdc(OFS_DRV, ~exp_rate(8'h00) & 8'h00 | d);
    $display("test registers done");
    wr(OFS_MISC, 8'h20);
    cyc(3);
    chk({7'h0, special_mode}, 8'h01);
    chk({2'h0, rate_sel}, {2'h0, SPEC_LANE_DEF});
    chk({5'h0, swing_sel}, {5'h0, SPEC_SWING_DEF});
    repeat (3)
    begin
      d = xs();
      wr(OFS_DRV, d);
      wr(OFS_LANE, d);
      cyc(2);
      chk({5'h0, swing_sel}, {5'h0, d[7:5]});
      chk({6'h0, preemph_sel}, {6'h0, d[1:0]});
      chk({2'h0, rate_sel}, exp_rate(d));
    end
    $display("test special mode done");
    wr(OFS_MISC, 8'h08);
    for (int i = 0; i < 10 && power_state !== ST_PDN; i++)
      cyc(1);
    cs(ST_PDN);
    rdc(OFS_DRV, 8'h00);
    oe_pin = 1'b0;
    cyc(10);
    cs(ST_PDN);
    chk({cfg_bus_en, ddc_en, clk_rx_en, lane_tx_en}, 8'h00);
    oe_pin = 1'b1;
    cyc(10);
    cs(ST_STBY1);
    rdc(OFS_MISC, MISC_RST);
    wr(OFS_MISC, 8'h02);
    rdc(OFS_MISC, 8'h02);
    $display("test power down done");
    // Hot-plug low spells: a short high restarts the count
    u_rpm_src_model.set_hpd(1'b0);
    cyc(6);
    chk({7'h0, hpd_out}, 8'h00);
    cyc(30);
    u_rpm_src_model.set_hpd(~hpd_out);
    cyc(6);
    u_rpm_src_model.set_hpd(1'b0);
    cyc(30);
    cs(ST_STBY1);
    cyc(40);
    cs(ST_PDN);
    u_rpm_src_model.set_hpd(1'b1);
    cyc(10);
    cs(ST_STBY1);
    $display("test hot-plug done");
    summarize();
  end
endmodule // redriver_power_mode_control_bench
